/* include/clock_power_cfg.svh */
// Constants for the sensor clock and power access block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef CLOCK_POWER_CFG_SVH
`define CLOCK_POWER_CFG_SVH
`define CLOCK_SOURCE_AUTO 3'h1
`define LOW_POWER_ENABLE_BIT 5
`define BANK_LO 4
`define BANK_HI 5
`define REG_BANK_SELECT 7'h7f
`define REG_LOW_POWER_CONFIG 7'h05
`define REG_POWER_CONTROL_ONE 7'h06
`define REG_POWER_CONTROL_TWO 7'h07
`define REG_INT_PIN_CONFIG 7'h0f
`define REG_INT_ENABLE 7'h10
`define REG_QUEUE_CONFIG 7'h76
`define REG_QUEUE_COUNT_HIGH 7'h70
`define REG_QUEUE_COUNT_LOW 7'h71
`define REG_QUEUE_DATA 7'h72
`define REG_AUX_CLOCK_CODE 7'h01
`define GYRO_OFF_CODE 3'h7
`define TIMEBASE_DEV_RESET 8'h00
`define SETTLE_SAMPLES_DEFAULT 4'h4
`endif

/* include/clock_power_pkg.sv */
// Types for the sensor clock and power access block.
// Assumes the constants header is on the include path.
`include "clock_power_cfg.svh"
package clock_power_pkg;
    typedef enum logic [0:0] {SRC_RELAX = 1'b0, SRC_PLL = 1'b1} clk_src_t;
    // One register write request from the serial port.
    typedef struct packed {
        logic valid;
        logic [6:0] addr;
        logic [7:0] data;
    } reg_write_t;
    // Divider setting for the auxiliary bus clock.
    typedef struct packed {
        logic defined;
        logic [4:0] period;
        logic [4:0] high;
    } aux_div_t;
endpackage : clock_power_pkg

/* rtl/sensor_clock_and_power_access.sv */
// Clock source selection, auxiliary clock code table and low-power write blocking.
// Assumes register writes arrive synchronously on ref_clk as one-cycle requests.
// Overview of operation
// - With select 1, use relaxation oscillator while only accelerometer runs.
// - With automatic selection, use PLL whenever gyroscope is on.
// - Expose read-only PLL deviation code, 0.079 percent per step, ten percent span.
// - Accelerometer-only clock stays nominal regardless of deviation code.
// - Codes 0,2,5 give 370.29 kHz half duty; code 4 42.86; code 1 undefined.
// - Codes 3,9,13 432 kHz half; 10,11 41.67; 12 471.27; 8 304.94.
// - Code 6 gives 345.60 kHz at 40 percent; 7,14,15 at 46.67 percent.
// - While low-power bit 5 is set, non-exempt writes may be refused.
// - Bank 0 exempt set stays writable in low-power mode.
// - Banks 1 to 3 keep only bank select writable in low-power mode.
// - Gyro switch to low-noise yields several unsettled samples.
// - Bank select bits 5:4 choose the register bank for later accesses.
`timescale 1ns/1ps
`default_nettype none
`include "clock_power_cfg.svh"
module sensor_clock_and_power_access #(
    parameter logic [3:0] SETTLE_SAMPLES = `SETTLE_SAMPLES_DEFAULT,
    parameter logic [7:0] TIMEBASE_DEV = `TIMEBASE_DEV_RESET
) (
    input wire logic ref_clk, // System clock, 50 MHz.
    input wire logic reset, // Synchronous active-high reset.
    input wire clock_power_pkg::reg_write_t wr_req, // Register write request.
    input wire logic gyro_low_noise, // Gyro filter mode: 1 low noise.
    input wire logic sample_tick, // One-cycle pulse per gyro output sample.
    output logic [2:0] clock_source_select, // Stored clock source select.
    output logic [1:0] bank_select, // Current register bank.
    output logic digital_low_power_enable, // Low-power bit of power control one.
    output logic [7:0] power_control_one, // Power control one register.
    output logic [7:0] power_control_two, // Power control two register.
    output logic [7:0] pll_timebase_deviation, // Factory deviation code.
    output logic [3:0] aux_master_clock_code, // Auxiliary bus clock code.
    output clock_power_pkg::clk_src_t sys_clk_source, // Chosen system clock source.
    output logic use_deviation, // High when deviation code applies.
    output logic aux_clk_en, // Auxiliary clock level from divider.
    output logic write_done, // Pulse: a write was accepted.
    output logic write_blocked, // Pulse: write silently dropped.
    output logic gyro_unsettled // High while gyro samples settle.
);
    import clock_power_pkg::*;

    logic exempt;
    logic accept;
    logic gyro_on;
    aux_div_t div;
    logic [4:0] aux_cnt_r;
    logic [3:0] settle_r;
    logic low_noise_r;
    logic [7:0] misc_regs_r [0:3];

    // Exempt registers depend on the bank; outside bank 0 only bank select passes.
    // The bank used is the one standing before the write, so a bank change applies next time.
    always_comb
    begin
        exempt = (wr_req.addr == `REG_BANK_SELECT);
        if (bank_select == 2'h0)
        begin
            unique case (wr_req.addr)
                `REG_LOW_POWER_CONFIG, `REG_POWER_CONTROL_ONE, `REG_POWER_CONTROL_TWO,
                `REG_INT_PIN_CONFIG, `REG_INT_ENABLE, `REG_QUEUE_COUNT_HIGH,
                `REG_QUEUE_COUNT_LOW, `REG_QUEUE_DATA, `REG_QUEUE_CONFIG: exempt = 1'b1;
                default: ;
            endcase
        end
    end

    // Low-power mode refuses any write outside the exempt set.
    assign accept = wr_req.valid && (!digital_low_power_enable || exempt);

    // Bank select register; it stays writable in every bank and mode.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            bank_select <= 2'h0;
        else if (accept && wr_req.addr == `REG_BANK_SELECT)
            bank_select <= wr_req.data[`BANK_HI:`BANK_LO];
    end

    // Power control registers, with their decoded fields kept as outputs.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            power_control_one <= 8'h00;
            power_control_two <= 8'h00;
            clock_source_select <= 3'h0;
            digital_low_power_enable <= 1'b0;
        end
        else if (accept && bank_select == 2'h0)
        begin
            if (wr_req.addr == `REG_POWER_CONTROL_ONE)
            begin
                power_control_one <= wr_req.data;
                clock_source_select <= wr_req.data[2:0];
                digital_low_power_enable <= wr_req.data[`LOW_POWER_ENABLE_BIT];
            end
            if (wr_req.addr == `REG_POWER_CONTROL_TWO)
                power_control_two <= wr_req.data;
        end
    end

    // Auxiliary clock code lives in bank 3, so it is a blockable register.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            aux_master_clock_code <= 4'h0;
        else if (accept && bank_select == 2'h3 && wr_req.addr == `REG_AUX_CLOCK_CODE)
            aux_master_clock_code <= wr_req.data[3:0];
    end

    // A small store for the blockable bank 0 registers at addresses 0 to 3.
    // Nothing reads it back here; it gives a refused write a real target to leave untouched.
    always_ff @(posedge ref_clk)
    begin
        if (accept && bank_select == 2'h0 && wr_req.addr[6:2] == 5'h0)
            misc_regs_r[wr_req.addr[1:0]] <= wr_req.data;
    end

    // Write outcome pulses; a refused write is not an error, just a no-op.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            write_done <= 1'b0;
            write_blocked <= 1'b0;
        end
        else
        begin
            write_done <= accept;
            write_blocked <= wr_req.valid && !accept;
        end
    end

    // Gyro is on unless all three gyro disable bits are set.
    assign gyro_on = (power_control_two[2:0] != `GYRO_OFF_CODE);

    // Automatic source choice; other select codes keep the oscillator.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            sys_clk_source <= SRC_RELAX;
            use_deviation <= 1'b0;
        end
        else
        begin
            if (clock_source_select == `CLOCK_SOURCE_AUTO && gyro_on)
                sys_clk_source <= SRC_PLL;
            else
                sys_clk_source <= SRC_RELAX;
            use_deviation <= (clock_source_select == `CLOCK_SOURCE_AUTO) && gyro_on;
        end
    end

    // Factory deviation code is a fixed, read-only value.
    // Software should scale its timing by it only while the PLL is the source.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            pll_timebase_deviation <= TIMEBASE_DEV;
    end

    // Code table as period and high time in system clock ticks.
    // Only duty and relative rate are kept; absolute rates scale with ref_clk.
    always_comb
    begin
        unique case (aux_master_clock_code)
            4'h0, 4'h2, 4'h5: div = '{1'b1, 5'd14, 5'd7};
            4'h4: div = '{1'b1, 5'd14, 5'd6};
            4'h1: div = '{1'b0, 5'd14, 5'd7};
            4'h3, 4'h9, 4'hd: div = '{1'b1, 5'd12, 5'd6};
            4'ha, 4'hb: div = '{1'b1, 5'd12, 5'd5};
            4'hc: div = '{1'b1, 5'd11, 5'd5};
            4'h8: div = '{1'b1, 5'd17, 5'd8};
            4'h6: div = '{1'b1, 5'd15, 5'd6};
            default: div = '{1'b1, 5'd15, 5'd7};
        endcase
    end

    // Divider for the auxiliary clock; an undefined code holds the clock low.
    always_ff @(posedge ref_clk)
    begin
        if (reset || !div.defined)
        begin
            aux_cnt_r <= 5'h0;
            aux_clk_en <= 1'b0;
        end
        else
        begin
            aux_cnt_r <= (aux_cnt_r >= div.period - 5'd1) ? 5'h0 : aux_cnt_r + 5'd1;
            aux_clk_en <= (aux_cnt_r < div.high);
        end
    end

    // Flag unsettled samples after a low-power to low-noise gyro switch.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            low_noise_r <= 1'b0;
            settle_r <= 4'h0;
            gyro_unsettled <= 1'b0;
        end
        else
        begin
            low_noise_r <= gyro_low_noise;
            if (gyro_low_noise && !low_noise_r && gyro_on)
                settle_r <= SETTLE_SAMPLES;
            else if (sample_tick && settle_r != 4'h0)
                settle_r <= settle_r - 4'd1;
            gyro_unsettled <= (settle_r != 4'h0);
        end
    end
endmodule : sensor_clock_and_power_access
`default_nettype wire

/* testbench/sensor_clock_and_power_access_checker.sv */
// Port checker for the clock and power access block.
// Assumes a bind to the design top and one clock.
`timescale 1ns/1ps
`default_nettype none
module sensor_clock_and_power_access_checker (
    input wire logic ref_clk, // Clock.
    input wire logic reset, // Reset.
    input wire clock_power_pkg::reg_write_t wr_req, // Request.
    input wire logic [2:0] clock_source_select, // Select.
    input wire logic [1:0] bank_select, // Bank.
    input wire logic digital_low_power_enable, // Low power.
    input wire logic [7:0] power_control_two, // Power two.
    input wire clock_power_pkg::clk_src_t sys_clk_source, // Source.
    input wire logic use_deviation, // Deviation.
    input wire logic write_done, // Taken.
    input wire logic write_blocked // Refused.
);
    import clock_power_pkg::*;
    // Writes that low-power mode must let through; other banks keep only bank select.
    wire logic ex = bank_select == 2'h0 ? wr_req.addr inside {7'h05, 7'h06, 7'h07, 7'h0f,
        7'h10, 7'h70, 7'h71, 7'h72, 7'h76, 7'h7f} : wr_req.addr == 7'h7f;
    wire logic au = clock_source_select == 3'h1;
    wire logic off = power_control_two[2:0] == 3'h7;
    wire logic v = wr_req.valid;
    wire logic lp = digital_low_power_enable;
    wire logic [6:0] a = wr_req.addr;
    wire logic [7:0] d = wr_req.data;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    property p_relax; au && off |=> sys_clk_source == SRC_RELAX; endproperty
    a_relax: assert property (p_relax) else $error("no relax");
    property p_pll; au && !off |=> sys_clk_source == SRC_PLL; endproperty
    a_pll: assert property (p_pll) else $error("no pll");
    property p_nom; !au || off |=> !use_deviation; endproperty
    a_nom: assert property (p_nom) else $error("deviation on");
    property p_blk; v && lp && !ex |=> write_blocked && !write_done; endproperty
    a_blk: assert property (p_blk) else $error("not refused");
    property p_acc; v && (ex || !lp) |=> write_done && !write_blocked; endproperty
    a_acc: assert property (p_acc) else $error("not taken");
    property p_bank; v && a == 7'h7f |=> bank_select == $past(d[5:4]); endproperty
    a_bank: assert property (p_bank) else $error("bad bank");
    property p_sel; v && a == 7'h06 && bank_select == 2'h0 |=>
        clock_source_select == $past(d[2:0]) && lp == $past(d[5]); endproperty
    a_sel: assert property (p_sel) else $error("bad power one");
    property p_ans; write_done || write_blocked |-> $past(v); endproperty
    a_ans: assert property (p_ans) else $error("answer without request");
endmodule : sensor_clock_and_power_access_checker
bind sensor_clock_and_power_access sensor_clock_and_power_access_checker checker_inst (
    .ref_clk, .reset, .wr_req, .clock_source_select, .bank_select, .digital_low_power_enable,
    .power_control_two, .sys_clk_source, .use_deviation, .write_done, .write_blocked);
`default_nettype wire

/* testbench/host_model.sv */
// Host model issuing serial register writes one at a time.
// Assumes the block answers one cycle after taking a request.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic ref_clk, // Clock.
    output var clock_power_pkg::reg_write_t wr_req, // Request.
    input wire logic write_done, // Taken.
    input wire logic write_blocked // Refused.
);
    import clock_power_pkg::*;
    initial wr_req = '0;
    // Never interleaved; idle fields carry inverted data so stale values show.
    task automatic write(input logic [6:0] a, input logic [7:0] d, output logic [1:0] r);
        @(negedge ref_clk);
        wr_req = {1'b1, a, d};
        @(negedge ref_clk);
        wr_req = {1'b0, ~a, ~d};
        r = {write_done, write_blocked};
        // Gyro just turned off: hold 22 us, 1100 cycles, before more traffic.
        if (a == 7'h07 && d[2:0] == 3'h7) repeat (1100) @(negedge ref_clk);
    endtask : write
endmodule : host_model
`default_nettype wire

/* testbench/sensor_clock_and_power_access_bench.sv */
// Self-checking bench for the clock and power access block.
// Assumes the host model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
    $display("[ERR] %0t got %0h want %0h", $time, a, e); end end
module sensor_clock_and_power_access_bench;
    import clock_power_pkg::*;
    // Divider period and high ticks per aux code; code 1 never toggles.
    localparam int PER [16] = '{14, 0, 14, 12, 14, 14, 15, 15, 17, 12, 12, 12, 11, 12, 15, 15};
    localparam int HI [16] = '{7, 0, 7, 6, 6, 7, 6, 7, 8, 6, 5, 5, 5, 6, 7, 7};
    localparam logic [15:0] SEQ [9] = '{16'h7f00, 16'h0621, 16'h005a, 16'h7601, 16'h7f30,
        16'h0105, 16'h7f00, 16'h0601, 16'h005a};
    localparam logic [8:0] OK = 9'h1db;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    reg_write_t wr_req;
    logic [1:0] bank_select;
    logic [7:0] pll_timebase_deviation;
    logic [3:0] aux_master_clock_code;
    clk_src_t sys_clk_source;
    logic use_deviation, aux_clk_en, write_done, write_blocked;
    logic [2:0] clock_source_select;
    logic digital_low_power_enable, gyro_unsettled;
    logic [7:0] power_control_one, power_control_two;
    logic gyro_low_noise = 1'b0;
    logic sample_tick = 1'b0;
    int num_errors = 0;
    int checks = 0;
    sensor_clock_and_power_access #(.TIMEBASE_DEV(8'h0c)) sensor_clock_and_power_access_inst (
        .ref_clk, .reset, .wr_req, .gyro_low_noise, .sample_tick,
        .clock_source_select, .bank_select, .digital_low_power_enable,
        .power_control_one, .power_control_two, .pll_timebase_deviation,
        .aux_master_clock_code, .sys_clk_source, .use_deviation, .aux_clk_en,
        .write_done, .write_blocked, .gyro_unsettled);
    host_model host_model_inst (.ref_clk, .wr_req, .write_done, .write_blocked);
    always #10 ref_clk = ~ref_clk;
    // Prints the verdict and ends the run.
    task automatic stop_test;
        if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    // Writes through the host and checks which answer came back.
    task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic [1:0] e);
        logic [1:0] r;
        host_model_inst.write(a, d, r);
        `CHK(r, e)
    endtask : wr
    // Sets an aux code, then measures one period and its high time.
    task automatic meas(input int c);
        int r1 = -1;
        int r2 = -1;
        int h = 0;
        logic p;
        wr(7'h01, 8'(c), 2'b10);
        `CHK(aux_master_clock_code, 4'(c))
        p = aux_clk_en;
        for (int i = 0; i < 600; i++)
        begin
            @(negedge ref_clk);
            if (aux_clk_en && !p && r1 >= 0 && r2 < 0) r2 = i;
            if (aux_clk_en && !p && r1 < 0) r1 = i;
            if (r1 >= 0 && r2 < 0 && aux_clk_en) h++;
            p = aux_clk_en;
        end
        `CHK(r1 < 0, PER[c] == 0)
        `CHK(r2 - r1, PER[c])
        `CHK(h, HI[c])
    endtask : meas
    // Main sequence: clock source, aux codes, then low-power write blocking.
    initial
    begin
        repeat (2) @(negedge ref_clk);
        reset = 1'b0;
        `CHK(pll_timebase_deviation, 8'h0c)
        wr(7'h06, 8'h01, 2'b10);
        `CHK(clock_source_select, 3'h1)
        wr(7'h07, 8'h07, 2'b10);
        `CHK(power_control_two, 8'h07)
        `CHK(sys_clk_source, SRC_RELAX)
        `CHK(use_deviation, 1'b0)
        wr(7'h07, 8'h00, 2'b10);
        repeat (2) @(negedge ref_clk);
        `CHK(sys_clk_source, SRC_PLL)
        wr(7'h7f, 8'h30, 2'b10);
        `CHK(bank_select, 2'h3)
        for (int c = 0; c < 16; c++) meas(c);
        for (int i = 0; i < 9; i++) wr(SEQ[i][14:8], SEQ[i][7:0], OK[i] ? 2'b10 : 2'b01);
        // Code 15 is left in place; its rate suits a slave limited to 400 kHz.
        `CHK(aux_master_clock_code, 4'hf)
        `CHK(power_control_one, 8'h01)
        `CHK(digital_low_power_enable, 1'b0)
        // Low-noise switch with the gyro on: the flag stands for four sample ticks.
        `CHK(gyro_unsettled, 1'b0)
        gyro_low_noise = 1'b1;
        repeat (2) @(negedge ref_clk);
        for (int i = 0; i < 4; i++)
        begin
            `CHK(gyro_unsettled, 1'b1)
            sample_tick = 1'b1;
            @(negedge ref_clk);
            sample_tick = 1'b0;
            @(negedge ref_clk);
        end
        `CHK(gyro_unsettled, 1'b0)
        stop_test();
    end
    // Cuts a hang short.
    initial
    begin
        #1000000;
        num_errors++;
        stop_test();
    end
endmodule : sensor_clock_and_power_access_bench
`default_nettype wire
